// >>> core/frsl_ctrl.sv
// Purpose: strap capture, reset sequencing, bias and loopback register bank
// Assumes: serial port is clocked by sclk pin sampled in clk domain
// Notes: hardware reset is the async rst_n, which the host drives as the reset line
module frsl_ctrl
    import frsl_pkg::*;
#(
    parameter int CAL_CYCLES = FRSL_CAL_CYCLES,
    parameter logic [7:0] TOP_DEF_HD = 8'h00,
    parameter logic [7:0] TOP_DEF_HD_CFG = 8'h01,
    parameter logic [7:0] TOP_DEF_FD = 8'h02,
    parameter logic [7:0] TOP_DEF_FD_CFG = 8'h03,
    parameter logic [7:0] LP_DEF_CFG = 8'h00
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_strap,
    input wire logic config_strap,
    input wire logic serial_port_select_n,
    input wire logic sclk,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    input wire logic [5:0] tx_data,
    input wire logic [11:0] conv_data,
    output logic [11:0] tx_path_data,
    output logic [5:0] rx_data_out,
    output logic rx_data_oe,
    output logic full_duplex,
    output logic cal_start,
    output logic [2:0] continuous_gain_amp_bias,
    output logic [1:0] sampled_gain_amp_bias,
    output logic [2:0] conv_bias
);
    // ========================================
    // Pin synchronisers
    logic [2:0] pins_s;
    logic [1:0] straps_s;
    logic sen_n_s;
    logic sclk_s;
    logic sdio_s;
    logic mode_s;
    logic cfg_s;

    frsl_sync #(.WIDTH(3), .INIT(3'h1)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({sdio_in, sclk, serial_port_select_n}),
        .dout(pins_s)
    );

    // Straps track the pins through reset, so the first edge after release sees them
    frsl_sync #(.WIDTH(2), .INIT(2'h0)) u_strap_sync (
        .clk(clk),
        .rst_n(1'b1),
        .din({config_strap, mode_strap}),
        .dout(straps_s)
    );
    assign sen_n_s = pins_s[0];
    assign sclk_s = pins_s[1];
    assign sdio_s = pins_s[2];
    assign mode_s = straps_s[0];
    assign cfg_s = straps_s[1];

    // ========================================
    // Strap capture and default selection
    logic strap_valid;
    logic mode_lat;
    logic cfg_lat;
    logic soft_reset;
    logic reload;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_valid <= 1'b0;
            mode_lat <= 1'b0;
            cfg_lat <= 1'b0;
        end else if (reload) begin
            // Straps sampled after release; synchroniser has settled by then
            strap_valid <= 1'b1;
            mode_lat <= mode_s;
            cfg_lat <= cfg_s;
        end
    end

    function automatic logic [7:0] top_default(input logic m, input logic c);
        case ({m, c})
            2'b00: top_default = TOP_DEF_HD;
            2'b01: top_default = TOP_DEF_HD_CFG;
            2'b10: top_default = TOP_DEF_FD;
            default: top_default = TOP_DEF_FD_CFG;
        endcase
    endfunction

    function automatic logic [7:0] lp_default(input logic c);
        lp_default = c ? LP_DEF_CFG : FRSL_ZERO;
    endfunction

    // ========================================
    // Serial port: sample on rising sclk, MSB first, bit 7 of addr = read
    frsl_sp_state_t sp_state;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] addr;
    logic rd;
    logic sclk_d;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_stb;
    logic [7:0] wr_data;
    logic port_active;

    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign port_active = !sen_n_s && strap_valid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_state <= FRSL_SP_IDLE;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            addr <= 8'h00;
            rd <= 1'b0;
            wr_stb <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (!port_active) begin
                sp_state <= FRSL_SP_IDLE;
                bit_cnt <= 3'h0;
            end else begin
                case (sp_state)
                    FRSL_SP_IDLE: begin
                        sp_state <= FRSL_SP_ADDR;
                        bit_cnt <= 3'h0;
                    end
                    FRSL_SP_ADDR: begin
                        if (sclk_rise) begin
                            shift <= {shift[6:0], sdio_s};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                rd <= shift[6];
                                addr <= {3'h0, shift[3:0], sdio_s};
                                sp_state <= FRSL_SP_DATA;
                            end
                        end
                    end
                    FRSL_SP_DATA: begin
                        if (sclk_rise) begin
                            shift <= {shift[6:0], sdio_s};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                wr_stb <= !rd;
                                wr_data <= {shift[6:0], sdio_s};
                                sp_state <= FRSL_SP_ADDR;
                            end
                        end
                    end
                    default: sp_state <= FRSL_SP_IDLE;
                endcase
            end
        end
    end

    // ========================================
    // Registers
    logic [7:0] top_control;
    logic [7:0] converter_low_power_ctrl;
    logic [7:0] test_loopback_ctrl;
    logic [7:0] receive_bias_ctrl;

    assign soft_reset = top_control[FRSL_BIT_SOFT_RESET];
    // Hardware release and soft reset share one reload path
    assign reload = !strap_valid || soft_reset;

    // Write strobe aimed at one register
    function automatic logic addr_hit(input logic stb, input logic [7:0] a,
                                      input logic [7:0] target);
        addr_hit = stb && (a == target);
    endfunction

    // strap-selected defaults; cleared at once as the reset line falls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_control <= FRSL_ZERO;
        end else if (reload) begin
            // soft reset bit self-clears, whatever the default holds
            top_control <= top_default(mode_s, cfg_s) & ~(8'h01 << FRSL_BIT_SOFT_RESET);
        end else if (addr_hit(wr_stb, addr, FRSL_ADDR_TOP_CONTROL)) begin
            top_control <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_low_power_ctrl <= FRSL_ZERO;
        end else if (reload) begin
            converter_low_power_ctrl <= lp_default(cfg_s);
        end else if (addr_hit(wr_stb, addr, FRSL_ADDR_CONV_LOW_POWER)) begin
            converter_low_power_ctrl <= wr_data;
        end
    end

    // Test modes drop back to normal operation on either reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_loopback_ctrl <= FRSL_ZERO;
        end else if (reload) begin
            test_loopback_ctrl <= FRSL_ZERO;
        end else if (addr_hit(wr_stb, addr, FRSL_ADDR_TEST_LOOPBACK)) begin
            test_loopback_ctrl <= wr_data;
        end
    end

    // bias register back to zero on either reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            receive_bias_ctrl <= FRSL_RX_BIAS_RESET;
        end else if (reload) begin
            receive_bias_ctrl <= FRSL_RX_BIAS_RESET;
        end else if (addr_hit(wr_stb, addr, FRSL_ADDR_RX_BIAS)) begin
            receive_bias_ctrl <= wr_data;
        end
    end

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        case (a)
            FRSL_ADDR_TOP_CONTROL: reg_read = top_control;
            FRSL_ADDR_CONV_LOW_POWER: reg_read = converter_low_power_ctrl;
            FRSL_ADDR_TEST_LOOPBACK: reg_read = test_loopback_ctrl;
            FRSL_ADDR_RX_BIAS: reg_read = receive_bias_ctrl;
            default: reg_read = FRSL_ZERO;
        endcase
    endfunction

    // Read data shifted out on falling sclk during data phase
    logic [7:0] rd_shift;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_shift <= 8'h00;
            sdio_out <= 1'b0;
            sdio_oe <= 1'b0;
        end else begin
            if (sp_state == FRSL_SP_ADDR && sclk_rise && bit_cnt == 3'h7) begin
                rd_shift <= reg_read({3'h0, shift[3:0], sdio_s});
            end else if (sp_state == FRSL_SP_DATA && sclk_fall) begin
                sdio_out <= rd_shift[7];
                rd_shift <= {rd_shift[6:0], 1'b0};
            end
            sdio_oe <= port_active && rd && sp_state == FRSL_SP_DATA;
        end
    end

    // ========================================
    // Calibration start on reset release
    // only hardware reset calibrates; start on release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_start <= 1'b0;
        end else begin
            cal_start <= !strap_valid;
        end
    end

    // ========================================
    // Bias outputs
    logic [2:0] next_conv_bias;
    always_comb begin
        if (converter_low_power_ctrl[FRSL_BIT_CONV_LOW_POWER]) begin
            next_conv_bias = FRSL_CONV_LOW_POWER_CODE;
        end else begin
            next_conv_bias = receive_bias_ctrl[FRSL_CONV_MSB:FRSL_CONV_LSB];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            continuous_gain_amp_bias <= 3'h0;
            sampled_gain_amp_bias <= 2'h0;
            conv_bias <= 3'h0;
        end else begin
            continuous_gain_amp_bias <= receive_bias_ctrl[FRSL_CGA_MSB:FRSL_CGA_LSB];
            sampled_gain_amp_bias <= receive_bias_ctrl[FRSL_SGA_MSB:FRSL_SGA_LSB];
            conv_bias <= next_conv_bias;
        end
    end

    // duplex mode follows the latched strap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            full_duplex <= 1'b0;
        end else begin
            full_duplex <= mode_lat;
        end
    end

    // ========================================
    // Data paths and loopback
    // no path here touches filter state; resets leave it alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_path_data <= 12'h000;
        end else if (test_loopback_ctrl[FRSL_BIT_ANALOG_LOOP]) begin
            // converter words into transmit path, any mode
            tx_path_data <= conv_data;
        end else begin
            tx_path_data <= {tx_data, 6'h00};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_out <= 6'h00;
        end else if (test_loopback_ctrl[FRSL_BIT_DIGITAL_LOOP] && mode_lat) begin
            rx_data_out <= tx_data;
        end else begin
            rx_data_out <= conv_data[11:6];
        end
    end

    // register-controlled three-state; off until straps are latched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_oe <= 1'b0;
        end else begin
            rx_data_oe <= strap_valid && !test_loopback_ctrl[FRSL_BIT_RX_TRISTATE];
        end
    end
endmodule // frsl_ctrl

// >>> core/frsl_sync.sv
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: single clock domain after the synchroniser
// Notes: output changes only when second and third stages agree
module frsl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Per bit: take new level only when the last two stages match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= INIT;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule // frsl_sync

// >>> pkg/frsl_pkg.sv
// Purpose: constants for the front-end reset, strap and loopback control block
// Assumes: 8-bit serial-port register map, 50 MHz system clock
// Notes: strap-dependent default values are plain parameters of neutral value
package frsl_pkg;

    // ========================================
    // Register offsets
    localparam logic [7:0] FRSL_ADDR_TOP_CONTROL = 8'h00;
    localparam logic [7:0] FRSL_ADDR_CONV_LOW_POWER = 8'h07;
    localparam logic [7:0] FRSL_ADDR_TEST_LOOPBACK = 8'h0D;
    localparam logic [7:0] FRSL_ADDR_RX_BIAS = 8'h13;

    // ========================================
    // Field positions
    localparam int FRSL_BIT_SOFT_RESET = 5;
    localparam int FRSL_BIT_CONV_LOW_POWER = 4;
    localparam int FRSL_BIT_ANALOG_LOOP = 7;
    localparam int FRSL_BIT_DIGITAL_LOOP = 6;
    localparam int FRSL_BIT_RX_TRISTATE = 5;
    localparam int FRSL_CGA_MSB = 7;
    localparam int FRSL_CGA_LSB = 5;
    localparam int FRSL_SGA_MSB = 4;
    localparam int FRSL_SGA_LSB = 3;
    localparam int FRSL_CONV_MSB = 2;
    localparam int FRSL_CONV_LSB = 0;
    localparam logic [2:0] FRSL_CONV_LOW_POWER_CODE = 3'h3;

    // ========================================
    // Reset values
    localparam logic [7:0] FRSL_RX_BIAS_RESET = 8'h00;
    localparam logic [7:0] FRSL_ZERO = 8'h00;

    // ========================================
    // Timing
    localparam int FRSL_CLK_MHZ = 50;
    localparam int FRSL_CAL_TIME_US = 100;
    localparam int FRSL_CAL_CYCLES = FRSL_CAL_TIME_US * FRSL_CLK_MHZ;

    // ========================================
    // Serial port states
    typedef enum logic [1:0] {
        FRSL_SP_IDLE = 2'b00,
        FRSL_SP_ADDR = 2'b01,
        FRSL_SP_DATA = 2'b11
    } frsl_sp_state_t;

endpackage

// >>> tb/frontend_reset_strap_loopback_ctrl_test.sv
// Purpose: self-checking bench for the reset, strap and loopback block
// Assumes: default calibration count, host model on the serial port
// Notes: power-up hold shortened to a few cycles
`define CHK(nm, ex, ac) \
    begin \
        cmp_count++; \
        if ((ac) !== (ex)) begin \
            fail_count++; \
            $display("unexpected %s: expected %0h seen %0h", nm, ex, ac); \
        end \
    end
module frontend_reset_strap_loopback_ctrl_test import frsl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 40000;
    localparam logic [7:0] DEF [4] = '{8'h41, 8'h12, 8'h84, 8'h18};
    logic clk = 1'b0;
    logic rst_n, mode_strap, config_strap, sdio_out, sdio_oe, rx_data_oe;
    logic serial_port_select_n, sclk, sdio_in, full_duplex, cal_start;
    logic [5:0] tx_data, rx_data_out;
    logic [11:0] conv_data, tx_path_data;
    logic [2:0] cga, conv_bias;
    logic [1:0] sga;
    logic [7:0] q;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int cal_n = 0;

    frsl_ctrl #(.TOP_DEF_HD(DEF[0]), .TOP_DEF_HD_CFG(DEF[1]), .TOP_DEF_FD(DEF[2]),
        .TOP_DEF_FD_CFG(DEF[3])) dut (.clk(clk), .rst_n(rst_n), .mode_strap(mode_strap),
        .config_strap(config_strap), .serial_port_select_n(serial_port_select_n),
        .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .tx_data(tx_data), .conv_data(conv_data), .tx_path_data(tx_path_data),
        .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe), .full_duplex(full_duplex),
        .cal_start(cal_start), .continuous_gain_amp_bias(cga),
        .sampled_gain_amp_bias(sga), .conv_bias(conv_bias));
    frsl_host host (.clk(clk), .serial_port_select_n(serial_port_select_n), .sclk(sclk),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe));

    always #10 clk = ~clk;

    always @(posedge clk) begin
        cal_n = cal_n + int'(cal_start === 1'b1);
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            give_verdict();
        end
    end

    // ========================================
    // Tasks
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic do_reset(input logic m, input logic c);
        @(posedge clk);
        rst_n <= 1'b0;
        mode_strap <= m;
        config_strap <= c;
        // reset low well over 50 ns
        repeat (4) @(posedge clk);
        cal_n = 0;
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer({3'h0, a[4:0]}, d, 1'b1, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
        host.xfer({3'h4, a[4:0]}, 8'h00, 1'b1, q);
        `CHK(nm, ex, q)
    endtask

    // ========================================
    // Tests
    initial begin
        rst_n = 1'b0;
        mode_strap = 1'b0;
        config_strap = 1'b0;
        tx_data = 6'h2D;
        conv_data = 12'hA5C;
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1], i[0]);
            `CHK("full_duplex", i[1], full_duplex)
            `CHK("calibration", 1, cal_n)
            rd(FRSL_ADDR_TOP_CONTROL, DEF[i], "top_control");
            rd(FRSL_ADDR_RX_BIAS, FRSL_RX_BIAS_RESET, "rx_bias");
        end
        $display("test strap_defaults done");
        wr(FRSL_ADDR_RX_BIAS, 8'hE9);
        `CHK("bias fields", 8'hE9, {cga, sga, conv_bias})
        rd(FRSL_ADDR_RX_BIAS, 8'hE9, "rx_bias");
        wr(FRSL_ADDR_CONV_LOW_POWER, 8'h10);
        `CHK("conv_bias", FRSL_CONV_LOW_POWER_CODE, conv_bias)
        rd(8'h05, 8'h00, "unmapped");
        host.xfer({3'h0, FRSL_ADDR_RX_BIAS[4:0]}, 8'h00, 1'b0, q);
        rd(FRSL_ADDR_RX_BIAS, 8'hE9, "rx_bias");
        $display("test bias done");
        wr(FRSL_ADDR_TOP_CONTROL, 8'h20);
        rd(FRSL_ADDR_TOP_CONTROL, DEF[3], "top_control");
        rd(FRSL_ADDR_RX_BIAS, 8'h00, "rx_bias");
        `CHK("conv_bias", 3'h0, conv_bias)
        `CHK("calibration", 1, cal_n)
        $display("test soft_reset done");
        wr(FRSL_ADDR_TEST_LOOPBACK, 8'h80);
        `CHK("tx_path", conv_data, tx_path_data)
        wr(FRSL_ADDR_TEST_LOOPBACK, 8'h40);
        `CHK("rx_data", tx_data, rx_data_out)
        `CHK("tx_path", {tx_data, 6'h00}, tx_path_data)
        wr(FRSL_ADDR_TEST_LOOPBACK, 8'h20);
        `CHK("rx_oe", 1'b0, rx_data_oe)
        wr(FRSL_ADDR_TEST_LOOPBACK, 8'h00);
        `CHK("rx_oe", 1'b1, rx_data_oe)
        do_reset(1'b0, 1'b1);
        wr(FRSL_ADDR_TEST_LOOPBACK, 8'hC0);
        `CHK("tx_path", conv_data, tx_path_data)
        `CHK("rx_data", conv_data[11:6], rx_data_out)
        rd(FRSL_ADDR_TEST_LOOPBACK, 8'hC0, "test_loopback");
        $display("test loopback done");
        give_verdict();
    end
endmodule // frontend_reset_strap_loopback_ctrl_test

bind frsl_ctrl frsl_ctrl_asserts u_chk (.clk(clk), .rst_n(rst_n),
    .serial_port_select_n(serial_port_select_n), .sdio_oe(sdio_oe), .tx_data(tx_data),
    .conv_data(conv_data), .tx_path_data(tx_path_data), .rx_data_out(rx_data_out),
    .rx_data_oe(rx_data_oe), .full_duplex(full_duplex), .cal_start(cal_start),
    .continuous_gain_amp_bias(continuous_gain_amp_bias),
    .sampled_gain_amp_bias(sampled_gain_amp_bias), .conv_bias(conv_bias));

// >>> tb/frsl_ctrl_asserts.sv
// Purpose: port checks for the reset, strap and loopback block
// Assumes: one clk domain, rst_n async active low
// Notes: cnt counts edges since hardware reset release, saturating
module frsl_ctrl_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_port_select_n,
    input wire logic sdio_oe,
    input wire logic [5:0] tx_data,
    input wire logic [11:0] conv_data,
    input wire logic [11:0] tx_path_data,
    input wire logic [5:0] rx_data_out,
    input wire logic rx_data_oe,
    input wire logic full_duplex,
    input wire logic cal_start,
    input wire logic [2:0] continuous_gain_amp_bias,
    input wire logic [1:0] sampled_gain_amp_bias,
    input wire logic [2:0] conv_bias
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] cnt;
    logic [7:0] bias;

    assign bias = {continuous_gain_amp_bias, sampled_gain_amp_bias, conv_bias};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 2'h0;
        end else if (cnt != 2'h3) begin
            cnt <= cnt + 2'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ========================================
    // Properties
    // Port stays idle only once the select has been high for a while
    sequence s_port_off;
        (cnt == 2'h3 && serial_port_select_n) [*8];
    endsequence

    property p_cal_hw;
        cal_start == (cnt == 2'h1);
    endproperty
    property p_tx_path;
        cnt == 2'h3 |-> tx_path_data == $past(conv_data)
            || tx_path_data == {$past(tx_data), 6'h00};
    endproperty
    property p_rx_out;
        cnt == 2'h3 && rx_data_oe |-> rx_data_out == $past(conv_data[11:6])
            || (full_duplex && rx_data_out == $past(tx_data));
    endproperty
    property p_rx_hd;
        cnt == 2'h3 && !full_duplex |-> rx_data_out == $past(conv_data[11:6]);
    endproperty
    property p_fd_stable;
        cnt == 2'h3 |-> $stable(full_duplex);
    endproperty
    property p_bias_rst;
        cnt == 2'h2 |-> bias == 8'h00;
    endproperty
    property p_sdio_quiet;
        s_port_off |-> !sdio_oe;
    endproperty
    property p_bias_hold;
        s_port_off |-> $stable(bias);
    endproperty

    a_cal_hw: assert property (p_cal_hw)
        else $error("calibration start not tied to reset release");
    a_tx_path: assert property (p_tx_path)
        else $error("transmit path source wrong");
    a_rx_out: assert property (p_rx_out)
        else $error("receive port source wrong");
    a_rx_hd: assert property (p_rx_hd)
        else $error("digital loopback active in half duplex");
    a_fd_stable: assert property (p_fd_stable)
        else $error("duplex mode changed outside reset");
    a_bias_rst: assert property (p_bias_rst)
        else $error("bias fields not zero after reset");
    a_sdio_quiet: assert property (p_sdio_quiet)
        else $error("serial data driven while port off");
    a_bias_hold: assert property (p_bias_hold)
        else $error("bias changed while port off");
endmodule // frsl_ctrl_asserts

// >>> tb/frsl_host.sv
// Purpose: host side of the serial control port
// Assumes: sclk slow against clk, address byte then data byte, MSB first
// Notes: released data line shows the inverse of its last bit
module frsl_host #(
    parameter int HALF = 10
) (
    input wire logic clk,
    output logic serial_port_select_n,
    output logic sclk,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        serial_port_select_n = 1'b1;
        sclk = 1'b0;
        sdio_in = 1'b0;
    end

    task automatic xfer(input logic [7:0] adr, input logic [7:0] dat, input logic sel,
                        output logic [7:0] q);
        logic [15:0] frame;
        frame = {adr, dat};
        q = 8'h00;
        @(posedge clk);
        // select held high leaves port off
        serial_port_select_n <= ~sel;
        repeat (HALF) @(posedge clk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b0;
            sdio_in <= frame[i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            q = (i < 8) ? {q[6:0], sdio_oe ? sdio_out : ~q[0]} : q;
            repeat (HALF) @(posedge clk);
        end
        sclk <= 1'b0;
        sdio_in <= ~frame[0];
        serial_port_select_n <= 1'b1;
        repeat (2 * HALF) @(posedge clk);
    endtask
endmodule // frsl_host
